// >>> bench/pll_cfg_props.sv
// Concurrent checks on the PLL pump/filter register bank ports
`timescale 1ns/1ps
`default_nettype none

module pll_cfg_props
(
  input wire logic                           mclk,
  input wire logic                           sys_rst,
  input wire logic [pll_cfg_pkg::ADDR_W-1:0] addr,
  input wire logic [pll_cfg_pkg::DATA_W-1:0] wr_data,
  input wire logic                           wr_stb,
  input wire logic                           rd_stb,
  input wire logic [pll_cfg_pkg::DATA_W-1:0] rd_data,
  input wire logic                           ramp_enable,
  input wire logic [7:0]                     pll_general_cfg,
  input wire logic                           pump_bias_enable,
  input wire logic                           pump_bias_range_boost,
  input wire logic [3:0]                     pump_bias_magnitude,
  input wire logic [2:0]                     pump_source_current,
  input wire logic [2:0]                     pump_sink_current,
  input wire logic                           vco_filter_bypass,
  input wire logic [2:0]                     loop_pole_capacitance,
  input wire logic [3:0]                     loop_filter_resistance,
  input wire logic                           bias_ramping
);
  import pll_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Access sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence wr_gen; wr_stb && addr == OFS_GENERAL; endsequence
  sequence wr_lo;  wr_stb && addr == OFS_PUMP_LO; endsequence
  sequence wr_hi;  wr_stb && addr == OFS_PUMP_HI; endsequence
  sequence wr_flt; wr_stb && addr == OFS_FILTER;  endsequence
  sequence rd_hi;  rd_stb && addr == OFS_PUMP_HI; endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  general_store_a: assert property (
    wr_gen |=> pll_general_cfg == $past(wr_data))
    else $error("general byte not stored");
  bias_enable_a: assert property (
    wr_hi |=> pump_bias_enable == $past(wr_data[5]))
    else $error("bias enable not stored");
  // Applied values trail the stored fields by one cycle in the ramp block
  range_boost_a: assert property (
    (wr_hi ##0 !ramp_enable) |-> ##2
      pump_bias_range_boost == $past(wr_data[4], 2))
    else $error("range boost not applied");
  bias_mag_a: assert property (
    (wr_hi ##0 !ramp_enable) |-> ##2
      pump_bias_magnitude == $past(wr_data[3:0], 2))
    else $error("bias magnitude not applied");
  source_cur_a: assert property (
    wr_lo |=> pump_source_current == $past(wr_data[6:4]))
    else $error("source current not stored");
  sink_cur_a: assert property (
    wr_lo |=> pump_sink_current == $past(wr_data[2:0]))
    else $error("sink current not stored");
  filter_byte_a: assert property (
    wr_flt |=> {vco_filter_bypass, loop_pole_capacitance,
                loop_filter_resistance} == $past(wr_data))
    else $error("filter byte not stored");
  ramp_start_a: assert property (
    $rose(bias_ramping) |-> pump_bias_magnitude == 4'h0
                            && !pump_bias_range_boost)
    else $error("bias not cleared at switch");
  // Clamping to a lower target may drop at once, rising is one code a step
  ramp_step_a: assert property (
    bias_ramping && $past(bias_ramping) |-> {1'b0, pump_bias_magnitude}
      <= {1'b0, $past(pump_bias_magnitude)} + 5'h01)
    else $error("bias magnitude jumped during ramp");
  reserved_read_a: assert property (
    rd_hi |=> rd_data[7:6] == 2'h0)
    else $error("reserved pump bits not zero");

endmodule // pll_cfg_props

bind pll_pump_filter_cfg_regs pll_cfg_props pll_cfg_props_inst (
  .mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
  .ramp_enable(ramp_enable), .pll_general_cfg(pll_general_cfg),
  .pump_bias_enable(pump_bias_enable),
  .pump_bias_range_boost(pump_bias_range_boost),
  .pump_bias_magnitude(pump_bias_magnitude),
  .pump_source_current(pump_source_current),
  .pump_sink_current(pump_sink_current),
  .vco_filter_bypass(vco_filter_bypass),
  .loop_pole_capacitance(loop_pole_capacitance),
  .loop_filter_resistance(loop_filter_resistance),
  .bias_ramping(bias_ramping));

`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the PLL pump/filter register bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import pll_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Signals and reference model
  // ----------------------------------------------------------------
  localparam int STEP = 3;
  logic              mclk, sys_rst, wr_stb, rd_stb;
  logic              xtal_switch, ramp_enable;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [7:0]        pll_general_cfg;
  logic              pump_bias_enable, pump_bias_range_boost;
  logic [3:0]        pump_bias_magnitude, loop_filter_resistance;
  logic [2:0]        pump_source_current, pump_sink_current;
  logic [2:0]        loop_pole_capacitance;
  logic              vco_filter_bypass, bias_ramping;
  logic [15:0]       lfsr;
  logic [7:0]        m_gen, m_lo, m_hi, m_flt;
  int                fail_count, total_checks;

  pll_pump_filter_cfg_regs #(.STEP_CYC(STEP)) pll_pump_filter_cfg_regs_inst (
    .mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .xtal_switch(xtal_switch), .ramp_enable(ramp_enable),
    .pll_general_cfg(pll_general_cfg),
    .pump_bias_enable(pump_bias_enable),
    .pump_bias_range_boost(pump_bias_range_boost),
    .pump_bias_magnitude(pump_bias_magnitude),
    .pump_source_current(pump_source_current),
    .pump_sink_current(pump_sink_current),
    .vco_filter_bypass(vco_filter_bypass),
    .loop_pole_capacitance(loop_pole_capacitance),
    .loop_filter_resistance(loop_filter_resistance),
    .bias_ramping(bias_ramping));

  always #5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Unmapped offsets read as zero
  function automatic logic [7:0] expect_rd(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_GENERAL: return m_gen;
      OFS_PUMP_LO: return m_lo;
      OFS_PUMP_HI: return m_hi;
      OFS_FILTER:  return m_flt;
      default:     return 8'h00;
    endcase
  endfunction

  task automatic give_verdict;
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge mclk);
    wr_stb  <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  task automatic put(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    wr(a, d);
    case (a)
      OFS_GENERAL: m_gen = d;
      OFS_PUMP_LO: m_lo = d;
      OFS_PUMP_HI: m_hi = d & 8'h3f;
      OFS_FILTER:  m_flt = d;
      default: ;
    endcase
    rd(a, expect_rd(a));
  endtask

  task automatic check_outs;
    chk(pll_general_cfg, m_gen);
    chk({1'b0, pump_source_current, 1'b0, pump_sink_current},
        m_lo & 8'h77);
    chk({2'b00, pump_bias_enable, pump_bias_range_boost,
         pump_bias_magnitude}, m_hi);
    chk({vco_filter_bypass, loop_pole_capacitance,
         loop_filter_resistance}, m_flt);
  endtask

  // Bounded wait on the ramp flag, optionally watching that bias stays zero
  task automatic wait_ramp(input logic lvl, input logic hold);
    int n;
    n = 0;
    while (bias_ramping !== lvl && n < 400)
    begin
      @(posedge mclk);
      #1;
      if (hold)
        chk({3'b000, pump_bias_range_boost, pump_bias_magnitude}, 8'h00);
      n++;
    end
    if (n >= 400)
    begin
      fail_count++;
      $display("[ERR] %0t ramp wait timed out", $time);
      give_verdict;
    end
  endtask

  task automatic do_reset;
    sys_rst <= 1'b1;
    m_gen = GENERAL_RST;
    m_lo  = 8'h33;
    m_hi  = 8'h03;
    m_flt = 8'h74;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    check_outs;
    for (int i = 0; i < 4; i++)
      rd(OFS_GENERAL + 6'(i), expect_rd(OFS_GENERAL + 6'(i)));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 0;
    sys_rst = 1;
    addr = '0;
    wr_data = '0;
    wr_stb = 0;
    rd_stb = 0;
    xtal_switch = 0;
    ramp_enable = 0;
    fail_count = 0;
    total_checks = 0;
    lfsr = 16'he394;
    do_reset;
    for (int i = 0; i < 32; i++)
    begin
      lfsr = lfsr_next(lfsr);
      put(OFS_GENERAL + 6'(lfsr[1:0] & 2'h3), lfsr[15:8]);
      check_outs;
    end
    put(OFS_PUMP_HI, 8'hff);
    put(OFS_PUMP_LO, 8'h88);
    wr(6'h20, 8'h5a);
    wr(OFS_STATUS, 8'hff);
    rd(6'h20, 8'h00);
    // Status shows applied bias while idle, switch and ramp flags clear
    rd(OFS_STATUS, {m_hi[3:0], 1'b0, m_hi[4], 2'b00});
    check_outs;
    // Switch with ramp: bias cleared, then restored to the target
    @(posedge mclk);
    ramp_enable <= 1'b1;
    put(OFS_PUMP_HI, 8'h35);
    @(posedge mclk);
    xtal_switch <= 1'b1;
    wait_ramp(1'b1, 1'b0);
    chk({3'b000, pump_bias_range_boost, pump_bias_magnitude}, 8'h00);
    @(posedge mclk);
    xtal_switch <= 1'b0;
    wait_ramp(1'b0, 1'b0);
    check_outs;
    // A programmed zero stays zero through the whole event
    put(OFS_PUMP_HI, 8'h20);
    @(posedge mclk);
    xtal_switch <= 1'b1;
    wait_ramp(1'b1, 1'b1);
    @(posedge mclk);
    xtal_switch <= 1'b0;
    wait_ramp(1'b0, 1'b1);
    check_outs;
    // Without ramping the programmed values hold across a switch
    put(OFS_PUMP_HI, 8'h1a);
    @(posedge mclk);
    ramp_enable <= 1'b0;
    xtal_switch <= 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    check_outs;
    @(posedge mclk);
    xtal_switch <= 1'b0;
    do_reset;
    give_verdict;
  end

endmodule // testbench

`default_nettype wire

// >>> core/pll_cfg_pkg.sv
// Offsets, field layout, reset values and timing of the PLL pump/filter bank
package pll_cfg_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_GENERAL = 6'h07;
  localparam logic [ADDR_W-1:0] OFS_PUMP_LO = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_PUMP_HI = 6'h09;
  localparam logic [ADDR_W-1:0] OFS_FILTER  = 6'h0a;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 6'h0f;

  // ----------------------------------------------------------------
  // Pump word fields (16-bit positions)
  // ----------------------------------------------------------------
  localparam int PUMP_EN_BIT    = 13;
  localparam int PUMP_BOOST_BIT = 12;
  localparam int PUMP_MAG_LSB   = 8;
  localparam int PUMP_MAG_W     = 4;
  localparam int PUMP_RSV7_BIT  = 7;
  localparam int PUMP_SRC_LSB   = 4;
  localparam int PUMP_RSV3_BIT  = 3;
  localparam int PUMP_SINK_LSB  = 0;
  localparam int PUMP_CUR_W     = 3;

  // ----------------------------------------------------------------
  // Filter byte fields
  // ----------------------------------------------------------------
  localparam int FILT_BYP_BIT = 7;
  localparam int FILT_CAP_LSB = 4;
  localparam int FILT_CAP_W   = 3;
  localparam int FILT_RES_LSB = 0;
  localparam int FILT_RES_W   = 4;

  // ----------------------------------------------------------------
  // Status byte fields
  // ----------------------------------------------------------------
  localparam int STAT_SWITCH_BIT = 0;
  localparam int STAT_RAMP_BIT   = 1;
  localparam int STAT_BOOST_BIT  = 2;
  localparam int STAT_MAG_LSB    = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GENERAL_RST = 8'h03;
  localparam logic       EN_RST      = 1'h0;
  localparam logic       BOOST_RST   = 1'h0;
  localparam logic [3:0] MAG_RST     = 4'h3;
  localparam logic       RSV_RST     = 1'h0;
  localparam logic [2:0] SRC_RST     = 3'h3;
  localparam logic [2:0] SINK_RST    = 3'h3;
  localparam logic       BYP_RST     = 1'h0;
  localparam logic [2:0] CAP_RST     = 3'h7;
  localparam logic [3:0] RES_RST     = 4'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RAMP_STEP_NS  = 1000;
  localparam int RAMP_STEP_CYC =
    (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// >>> core/pll_pump_filter_cfg_regs.sv
// PLL charge-pump and loop-filter configuration register bank
`timescale 1ns/1ps
`default_nettype none

module pll_pump_filter_cfg_regs
#(
  parameter int STEP_CYC = pll_cfg_pkg::RAMP_STEP_CYC
)
(
  input  wire logic                           mclk,
  input  wire logic                           sys_rst,
  input  wire logic [pll_cfg_pkg::ADDR_W-1:0] addr,
  input  wire logic [pll_cfg_pkg::DATA_W-1:0] wr_data,
  input  wire logic                           wr_stb,
  input  wire logic                           rd_stb,
  output var  logic [pll_cfg_pkg::DATA_W-1:0] rd_data,
  input  wire logic                           xtal_switch,
  input  wire logic                           ramp_enable,
  output var  logic [7:0]                     pll_general_cfg,
  output var  logic                           pump_bias_enable,
  output var  logic                           pump_bias_range_boost,
  output var  logic [3:0]                     pump_bias_magnitude,
  output var  logic [2:0]                     pump_source_current,
  output var  logic [2:0]                     pump_sink_current,
  output var  logic                           vco_filter_bypass,
  output var  logic [2:0]                     loop_pole_capacitance,
  output var  logic [3:0]                     loop_filter_resistance,
  output var  logic                           bias_ramping
);

  import pll_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Decode helper
  // ----------------------------------------------------------------
  function automatic logic hit
  (
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] ofs
  );
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  general_reg;
  logic        bias_en_reg;
  logic        boost_reg;
  logic [3:0]  magnitude_reg;
  logic        rsv7_reg;
  logic [2:0]  source_reg;
  logic        rsv3_reg;
  logic [2:0]  sink_reg;
  logic        bypass_reg;
  logic [2:0]  cap_reg;
  logic [3:0]  res_reg;
  logic [15:0] pump_wdata;
  logic        wr_general;
  logic        wr_pump_lo;
  logic        wr_pump_hi;
  logic        wr_filter;
  logic [2:0]  sync_reg;
  logic        switch_reg;
  logic [3:0]  applied_mag;
  logic        applied_boost;
  logic        ramp_busy;
  logic [7:0]  rd_next;

  // Byte lands in both lanes; each field picks its own position
  assign pump_wdata = {wr_data, wr_data};

  assign wr_general = wr_stb && hit(addr, OFS_GENERAL);
  assign wr_pump_lo = wr_stb && hit(addr, OFS_PUMP_LO);
  assign wr_pump_hi = wr_stb && hit(addr, OFS_PUMP_HI);
  assign wr_filter  = wr_stb && hit(addr, OFS_FILTER);

  // ----------------------------------------------------------------
  // General configuration byte
  // ----------------------------------------------------------------
  // writable reserved stored
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      general_reg <= GENERAL_RST;
    end
    else if (wr_general)
    begin
      general_reg <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Pump high byte
  // ----------------------------------------------------------------
  // bias enable
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bias_en_reg <= EN_RST;
    end
    else if (wr_pump_hi)
    begin
      bias_en_reg <= pump_wdata[PUMP_EN_BIT];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      boost_reg <= BOOST_RST;
    end
    else if (wr_pump_hi)
    begin
      boost_reg <= pump_wdata[PUMP_BOOST_BIT];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      magnitude_reg <= MAG_RST;
    end
    else if (wr_pump_hi)
    begin
      magnitude_reg <= pump_wdata[PUMP_MAG_LSB +: PUMP_MAG_W];
    end
  end

  // ----------------------------------------------------------------
  // Pump low byte
  // ----------------------------------------------------------------
  // source current
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      source_reg <= SRC_RST;
    end
    else if (wr_pump_lo)
    begin
      source_reg <= pump_wdata[PUMP_SRC_LSB +: PUMP_CUR_W];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sink_reg <= SINK_RST;
    end
    else if (wr_pump_lo)
    begin
      sink_reg <= pump_wdata[PUMP_SINK_LSB +: PUMP_CUR_W];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rsv7_reg <= RSV_RST;
      rsv3_reg <= RSV_RST;
    end
    else if (wr_pump_lo)
    begin
      rsv7_reg <= pump_wdata[PUMP_RSV7_BIT];
      rsv3_reg <= pump_wdata[PUMP_RSV3_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Filter byte
  // ----------------------------------------------------------------
  // filter bypass
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bypass_reg <= BYP_RST;
    end
    else if (wr_filter)
    begin
      bypass_reg <= wr_data[FILT_BYP_BIT];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cap_reg <= CAP_RST;
    end
    else if (wr_filter)
    begin
      cap_reg <= wr_data[FILT_CAP_LSB +: FILT_CAP_W];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      res_reg <= RES_RST;
    end
    else if (wr_filter)
    begin
      res_reg <= wr_data[FILT_RES_LSB +: FILT_RES_W];
    end
  end

  // ----------------------------------------------------------------
  // Crystal switch input
  // ----------------------------------------------------------------
  // Pin is asynchronous; accept a change only once stages two and
  // three agree, which costs four cycles of latency
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync_reg <= 3'h0;
    end
    else
    begin
      sync_reg <= {sync_reg[1:0], xtal_switch};
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      switch_reg <= 1'b0;
    end
    else if (sync_reg[1] == sync_reg[2])
    begin
      switch_reg <= sync_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // Applied bias around a crystal switch
  // ----------------------------------------------------------------
  // switch handling
  pump_bias_ramp #(
    .STEP_CYC (STEP_CYC)
  ) u_ramp (
    .mclk              (mclk),
    .sys_rst           (sys_rst),
    .switch_active     (switch_reg),
    .ramp_enable       (ramp_enable),
    .prog_magnitude    (magnitude_reg),
    .prog_boost        (boost_reg),
    .applied_magnitude (applied_mag),
    .applied_boost     (applied_boost),
    .ramping           (ramp_busy)
  );

  assign pump_bias_magnitude   = applied_mag;
  assign pump_bias_range_boost = applied_boost;
  assign bias_ramping          = ramp_busy;

  // ----------------------------------------------------------------
  // Analog control outputs
  // ----------------------------------------------------------------
  assign pll_general_cfg        = general_reg;
  assign pump_bias_enable       = bias_en_reg;
  assign pump_source_current    = source_reg;
  assign pump_sink_current      = sink_reg;
  assign vco_filter_bypass      = bypass_reg;
  assign loop_pole_capacitance  = cap_reg;
  assign loop_filter_resistance = res_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // pump high reserved bits read zero; pump low reserved bits read back as stored
  always_comb
  begin
    rd_next = 8'h00;
    case (addr)
      OFS_GENERAL:
      begin
        rd_next = general_reg;
      end
      OFS_PUMP_LO:
      begin
        rd_next = {rsv7_reg, source_reg, rsv3_reg, sink_reg};
      end
      OFS_PUMP_HI:
      begin
        rd_next = {2'h0, bias_en_reg, boost_reg, magnitude_reg};
      end
      OFS_FILTER:
      begin
        rd_next = {bypass_reg, cap_reg, res_reg};
      end
      OFS_STATUS:
      begin
        rd_next[STAT_SWITCH_BIT]          = switch_reg;
        rd_next[STAT_RAMP_BIT]            = ramp_busy;
        rd_next[STAT_BOOST_BIT]           = applied_boost;
        rd_next[STAT_MAG_LSB +: PUMP_MAG_W] = applied_mag;
      end
      default:
      begin
        rd_next = 8'h00;
      end
    endcase
  end

  // Data is valid only in the cycle after the strobe
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_data <= 8'h00;
    end
    else if (rd_stb)
    begin
      rd_data <= rd_next;
    end
    else
    begin
      rd_data <= 8'h00;
    end
  end

endmodule // pll_pump_filter_cfg_regs

`default_nettype wire

// >>> core/pump_bias_ramp.sv
// Applied pump bias across a crystal switch, with optional ramp back up
`timescale 1ns/1ps
`default_nettype none

module pump_bias_ramp
  import pll_cfg_pkg::*;
#(
  parameter int STEP_CYC = RAMP_STEP_CYC
)
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       switch_active,
  input  wire logic       ramp_enable,
  input  wire logic [3:0] prog_magnitude,
  input  wire logic       prog_boost,
  output var  logic [3:0] applied_magnitude,
  output var  logic       applied_boost,
  output var  logic       ramping
);

  localparam int CW = $clog2(STEP_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(STEP_CYC - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_SWITCH, ST_RAMP} ramp_state_e;

  ramp_state_e   state_reg;
  logic [CW-1:0] step_reg;

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  // applied values
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg         <= ST_IDLE;
      step_reg          <= '0;
      applied_magnitude <= MAG_RST;
      applied_boost     <= BOOST_RST;
      ramping           <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          applied_magnitude <= prog_magnitude;
          applied_boost     <= prog_boost;
          ramping           <= 1'b0;
          // Without ramping the programmed value holds throughout
          if (switch_active && ramp_enable)
          begin
            state_reg         <= ST_SWITCH;
            applied_magnitude <= 4'h0;
            applied_boost     <= 1'b0;
            ramping           <= 1'b1;
          end
        end
        ST_SWITCH:
        begin
          step_reg <= '0;
          if (!switch_active)
          begin
            state_reg <= ST_RAMP;
          end
        end
        ST_RAMP:
        begin
          // Clamped to the target, so a zero code never rises
          if (applied_magnitude >= prog_magnitude)
          begin
            applied_magnitude <= prog_magnitude;
            applied_boost     <= prog_boost;
            ramping           <= 1'b0;
            state_reg         <= ST_IDLE;
          end
          else if (step_reg == LAST)
          begin
            step_reg          <= '0;
            applied_magnitude <= applied_magnitude + 4'h1;
          end
          else
          begin
            step_reg <= step_reg + CW'(1);
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // pump_bias_ramp

`default_nettype wire
